/* src/bcr_defs.svh */
// Offsets, fields, reset values and timing counts of the bridge block
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// ****************************************************************
// Register map (printed offsets are register indices)
// ****************************************************************
`define BCR_IDX_CLK_CTRL 8'h5B
`define BCR_IDX_DIAG_CTRL 8'h5C
`define BCR_IDX_W 8
`define BCR_ADDR_W 10

// ****************************************************************
// Clock stop control fields
// ****************************************************************
`define BCR_CK_MODE 4
`define BCR_CK_PRI_EN 3
`define BCR_CK_KEEP 2
`define BCR_CK_SEC_EN 1
`define BCR_CK_STAT 0
`define BCR_CK_WMASK 8'h1E
`define BCR_CK_RST 8'h00

// ****************************************************************
// Diagnostic control fields
// ****************************************************************
`define BCR_DG_ARB_PERF 15
`define BCR_DG_PAR_MODE 14
`define BCR_DG_UP_LOCK 13
`define BCR_DG_DN_LOCK 12
`define BCR_DG_SEC_SLOW 11
`define BCR_DG_PRI_SLOW 10
`define BCR_DG_ARB_SERR 7
`define BCR_DG_ORDER 6
`define BCR_DG_SEC_EXT 5
`define BCR_DG_PRI_DIS 4
`define BCR_DG_PRI_EXT 3
`define BCR_DG_NO_IRETRY 2
`define BCR_DG_PARK_BR 1
`define BCR_DG_TEST 0
`define BCR_DG_WMASK 16'hFCFF
`define BCR_DG_RST 16'h1040
// Decoded diagnostic outputs at reset, parity bit down to parking bit
`define BCR_CFG_RST 8'hA6

// ****************************************************************
// Initial data phase limits in clocks
// ****************************************************************
`define BCR_IDP_SHORT 7'h10
`define BCR_IDP_LONG 7'h40
`define BCR_IDP_W 7

`endif

/* src/bcr_pkg.sv */
// Types shared by the bridge control block
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_RUN = 2'b00,
    BCR_STOPPING = 2'b01,
    BCR_STOPPED = 2'b11
  } bcr_clk_e;
endpackage

/* src/bcr_idp_cnt.sv */
// Initial data phase watchdog counter for one bus side
`timescale 1ns/1ps
`include "bcr_defs.svh"

module bcr_idp_cnt (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic extend,
  input wire logic start,
  input wire logic data_phase,
  output logic expired
);
  logic [`BCR_IDP_W-1:0] cnt_r;
  logic [`BCR_IDP_W-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic expired_r;
  wire [`BCR_IDP_W-1:0] limit = extend ? `BCR_IDP_LONG : `BCR_IDP_SHORT;
  wire at_limit = run_r && (cnt_r == limit - 7'h01);

  assign run_nxt = enable && (start || (run_r && !data_phase && !at_limit));
  assign cnt_nxt = start ? 7'h00 : cnt_r + 7'h01;
  assign expired = expired_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 7'h00;
      run_r <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      expired_r <= enable && at_limit && !data_phase && !start;
    end
  end
endmodule // bcr_idp_cnt

/* src/bcr_ctrl.sv */
// Clock stop control and diagnostic control registers with their effects
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "bcr_defs.svh"

module bcr_ctrl #(
  parameter int NUM_MASTERS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`BCR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pri_stop_req,
  input wire logic pri_pending,
  input wire logic sec_bus_idle,
  input wire logic downstream_txn,
  input wire logic secondary_clock_request_signal,
  input wire logic [NUM_MASTERS-1:0] sec_retried,
  input wire logic [NUM_MASTERS-1:0] sec_delayed,
  input wire logic arb_timer_expired,
  input wire logic pri_txn_start,
  input wire logic pri_data_phase,
  input wire logic sec_txn_start,
  input wire logic sec_data_phase,
  output logic sec_clk_stop,
  output logic pri_keep_clk_req,
  output logic [NUM_MASTERS-1:0] sec_top_tier,
  output logic parity_pass_en,
  output logic up_lock_en,
  output logic dn_lock_en,
  output logic sec_slow_decode,
  output logic pri_slow_decode,
  output logic sys_err,
  output logic order_en,
  output logic immediate_retry_en,
  output logic park_on_bridge,
  output logic pri_idp_expired,
  output logic sec_idp_expired
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  wire [5:0] raw_in = {pri_stop_req, pri_pending, sec_bus_idle,
    downstream_txn, secondary_clock_request_signal, arb_timer_expired};
  wire s_stop_req = sync_r[5];
  wire s_pending = sync_r[4];
  wire s_idle = sync_r[3];
  wire s_dn_txn = sync_r[2];
  wire s_sec_req = sync_r[1];
  wire s_arb_to = sync_r[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic [7:0] ck_r;
  logic [15:0] dg_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic ack_r;
  bcr_pkg::bcr_clk_e cs_r;
  bcr_pkg::bcr_clk_e cs_nxt;

  function automatic logic [31:0] bytes_mask(input logic [3:0] be);
    bytes_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Each access answers one cycle after it is seen; wait drops for one edge.
  wire req = (avs_read || avs_write) && !ack_r;
  wire [`BCR_IDX_W-1:0] idx = avs_address[`BCR_ADDR_W-1:2];
  wire hit_ck = idx == `BCR_IDX_CLK_CTRL;
  wire hit_dg = idx == `BCR_IDX_DIAG_CTRL;
  wire [31:0] bmask = bytes_mask(avs_byteenable);
  wire [31:0] wr_merge_ck = ({24'h000000, ck_r} & ~bmask) |
    (avs_writedata & bmask);
  wire [31:0] wr_merge_dg = ({16'h0000, dg_r} & ~bmask) |
    (avs_writedata & bmask);
  wire wr_ck = req && avs_write && hit_ck;
  wire wr_dg = req && avs_write && hit_dg;
  // Status bit live from state; reserved bits forced low
  wire [7:0] ck_view = (ck_r & `BCR_CK_WMASK) |
    {7'h00, cs_r == bcr_pkg::BCR_STOPPED};
  wire [15:0] dg_view = dg_r & `BCR_DG_WMASK;
  // Unmapped reads answer zero, unmapped writes are dropped
  wire [31:0] rd_sel = hit_ck ? {24'h000000, ck_view} :
    hit_dg ? {16'h0000, dg_view} : 32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_r <= `BCR_CK_RST;
      dg_r <= `BCR_DG_RST;
      rdata_r <= 32'h00000000;
      wait_r <= 1'b1;
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
      wait_r <= !req;
      if (req && avs_read) begin
        rdata_r <= rd_sel;
      end
      if (wr_ck) begin
        ck_r <= wr_merge_ck[7:0] & `BCR_CK_WMASK;
      end
      if (wr_dg) begin
        dg_r <= wr_merge_dg[15:0] & `BCR_DG_WMASK;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ****************************************************************
  // Secondary clock stop machine
  // ****************************************************************
  wire mode_idle = ck_r[`BCR_CK_MODE];
  wire pri_en = ck_r[`BCR_CK_PRI_EN];
  wire sec_en = ck_r[`BCR_CK_SEC_EN];
  wire keep = ck_r[`BCR_CK_KEEP];
  wire pri_stop = pri_en && s_stop_req;
  wire idle_stop = mode_idle && s_idle && !s_pending;
  wire restart = s_dn_txn || s_sec_req;
  wire stop_ok = sec_en && !restart && (pri_stop || idle_stop);

  // Restart wins over any stop condition so no transaction is starved
  always_comb begin
    cs_nxt = cs_r;
    unique case (cs_r)
      bcr_pkg::BCR_RUN: begin
        if (stop_ok) begin
          cs_nxt = bcr_pkg::BCR_STOPPING;
        end
      end
      bcr_pkg::BCR_STOPPING: begin
        cs_nxt = stop_ok ? bcr_pkg::BCR_STOPPED : bcr_pkg::BCR_RUN;
      end
      bcr_pkg::BCR_STOPPED: begin
        if (restart || !sec_en) begin
          cs_nxt = bcr_pkg::BCR_RUN;
        end
      end
      default: cs_nxt = bcr_pkg::BCR_RUN;
    endcase
  end

  logic stop_r;
  logic keep_r;
  logic [NUM_MASTERS-1:0] tier_r;
  logic serr_r;
  logic [7:0] cfg_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_r <= bcr_pkg::BCR_RUN;
      stop_r <= 1'b0;
      keep_r <= 1'b1;
    end else begin
      cs_r <= cs_nxt;
      stop_r <= cs_nxt == bcr_pkg::BCR_STOPPED;
      // Primary clock may stop only behind a stopped secondary clock
      keep_r <= keep || (cs_nxt != bcr_pkg::BCR_STOPPED);
    end
  end

  assign sec_clk_stop = stop_r;
  assign pri_keep_clk_req = keep_r;

  // ****************************************************************
  // Diagnostic effects
  // ****************************************************************
  wire [NUM_MASTERS-1:0] tier_nxt = dg_r[`BCR_DG_ARB_PERF] ?
    (sec_retried | sec_delayed) : {NUM_MASTERS{1'b0}};
  wire serr_nxt = dg_r[`BCR_DG_ARB_SERR] && s_arb_to;
  wire [7:0] cfg_nxt = {
    !dg_r[`BCR_DG_PAR_MODE],
    dg_r[`BCR_DG_UP_LOCK],
    dg_r[`BCR_DG_DN_LOCK],
    dg_r[`BCR_DG_SEC_SLOW],
    dg_r[`BCR_DG_PRI_SLOW],
    dg_r[`BCR_DG_ORDER],
    !dg_r[`BCR_DG_NO_IRETRY],
    dg_r[`BCR_DG_PARK_BR]
  };

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tier_r <= {NUM_MASTERS{1'b0}};
      serr_r <= 1'b0;
      cfg_r <= `BCR_CFG_RST;
    end else begin
      tier_r <= tier_nxt;
      serr_r <= serr_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign sec_top_tier = tier_r;
  assign sys_err = serr_r;
  assign parity_pass_en = cfg_r[7];
  assign up_lock_en = cfg_r[6];
  assign dn_lock_en = cfg_r[5];
  assign sec_slow_decode = cfg_r[4];
  assign pri_slow_decode = cfg_r[3];
  assign order_en = cfg_r[2];
  assign immediate_retry_en = cfg_r[1];
  assign park_on_bridge = cfg_r[0];

  // ****************************************************************
  // Initial data phase counters
  // ****************************************************************
  bcr_idp_cnt u_pri_idp (
    .clk(clk),
    .nrst(nrst),
    .enable(!dg_r[`BCR_DG_PRI_DIS]),
    .extend(dg_r[`BCR_DG_PRI_EXT]),
    .start(pri_txn_start),
    .data_phase(pri_data_phase),
    .expired(pri_idp_expired)
  );

  bcr_idp_cnt u_sec_idp (
    .clk(clk),
    .nrst(nrst),
    .enable(1'b1),
    .extend(dg_r[`BCR_DG_SEC_EXT]),
    .start(sec_txn_start),
    .data_phase(sec_data_phase),
    .expired(sec_idp_expired)
  );
endmodule // bcr_ctrl

/* dv/bcr_checker.sv */
// Port-level assertions for the bridge control block
`timescale 1ns/1ps
// ********
// Checker
// ********
module bcr_checker #(
  parameter int NUM_MASTERS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic downstream_txn,
  input wire logic secondary_clock_request_signal,
  input wire logic arb_timer_expired,
  input wire logic [NUM_MASTERS-1:0] sec_retried,
  input wire logic [NUM_MASTERS-1:0] sec_delayed,
  input wire logic sec_clk_stop,
  input wire logic pri_keep_clk_req,
  input wire logic [NUM_MASTERS-1:0] sec_top_tier,
  input wire logic sys_err,
  input wire logic pri_idp_expired,
  input wire logic sec_idp_expired
);
  logic req;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  assign req = avs_read | avs_write;
  ack_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in the next cycle");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  idle_wait_a: assert property (!req |=> avs_waitrequest)
    else $error("acknowledge without a request");
  restart_wins_a: assert property (
    (downstream_txn || secondary_clock_request_signal)[*4] |=> !sec_clk_stop)
    else $error("secondary clock not restarted");
  keep_run_a: assert property (
    !sec_clk_stop [*2] |-> pri_keep_clk_req)
    else $error("keep request dropped while clock runs");
  serr_quiet_a: assert property (
    !arb_timer_expired [*4] |=> !sys_err)
    else $error("system error without arbiter timeout");
  tier_cause_a: assert property (
    1'b1 |=> (sec_top_tier &
      ~($past(sec_retried) | $past(sec_delayed))) == '0)
    else $error("master promoted without cause");
  pri_pulse_a: assert property (
    pri_idp_expired |=> !pri_idp_expired)
    else $error("primary expiry not a single pulse");
  sec_pulse_a: assert property (
    sec_idp_expired |=> !sec_idp_expired)
    else $error("secondary expiry not a single pulse");
  cover property ($rose(sec_clk_stop));
  cover property ($rose(sys_err));
  cover property (sec_idp_expired);
endmodule // bcr_checker

/* dv/bcr_far_model.sv */
// Primary central resource and secondary masters facing the block
`timescale 1ns/1ps
module bcr_far_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] cmd,
  input wire logic [7:0] mst,
  output logic pri_stop_req,
  output logic pri_pending,
  output logic sec_bus_idle,
  output logic downstream_txn,
  output logic secondary_clock_request_signal,
  output logic arb_timer_expired,
  output logic [3:0] sec_retried,
  output logic [3:0] sec_delayed
);
  // Requests are levels held until the bench drops them, never pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {arb_timer_expired, secondary_clock_request_signal} <= '0;
      {downstream_txn, sec_bus_idle, pri_pending, pri_stop_req} <= '0;
      {sec_delayed, sec_retried} <= '0;
    end else begin
      {arb_timer_expired, secondary_clock_request_signal} <= cmd[5:4];
      {downstream_txn, sec_bus_idle, pri_pending, pri_stop_req} <= cmd[3:0];
      {sec_delayed, sec_retried} <= mst;
    end
  end
endmodule // bcr_far_model

/* dv/tb_top.sv */
// Self-checking bench for the bridge control block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
  logic [9:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, x = 32'h438F, r;
  logic [3:0] avs_byteenable = 4'hF, sec_retried, sec_delayed, sec_top_tier;
  logic [5:0] cmd = '0;
  logic [7:0] mst = '0, cfg;
  logic pri_txn_start = 0, sec_txn_start = 0;
  logic pri_data_phase = 0, sec_data_phase = 0;
  logic avs_waitrequest, pri_stop_req, pri_pending, sec_bus_idle;
  logic downstream_txn, secondary_clock_request_signal, arb_timer_expired;
  logic sec_clk_stop, pri_keep_clk_req, parity_pass_en, up_lock_en;
  logic dn_lock_en, sec_slow_decode, pri_slow_decode, sys_err, order_en;
  logic immediate_retry_en, park_on_bridge, pri_idp_expired, sec_idp_expired;
  logic [7:0] cv [7] = '{8'h0A, 8'h0E, 8'h02, 8'h08, 8'h12, 8'h12, 8'h02};
  logic [2:0] fv [7] = '{1, 1, 1, 1, 4, 6, 4};
  logic ev [7] = '{1, 1, 0, 0, 1, 0, 0};
  logic [31:0] dv [4] = '{32'h1040, 32'h1068, 32'h1050, 32'h1040};
  int pe [4] = '{16, 64, 0, 0};
  int se [4] = '{16, 64, 16, 0};
  int num_errors = 0, n_checks = 0, cyc = 0, pc, sc;
  logic [31:0] expq [$];
  assign cfg = {parity_pass_en, up_lock_en, dn_lock_en, sec_slow_decode,
    pri_slow_decode, order_en, immediate_retry_en, park_on_bridge};
  always #4 clk = ~clk;
  bcr_ctrl uut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .pri_stop_req, .pri_pending, .sec_bus_idle, .downstream_txn,
    .secondary_clock_request_signal, .sec_retried, .sec_delayed,
    .arb_timer_expired, .pri_txn_start, .pri_data_phase, .sec_txn_start,
    .sec_data_phase, .sec_clk_stop, .pri_keep_clk_req, .sec_top_tier,
    .parity_pass_en, .up_lock_en, .dn_lock_en, .sec_slow_decode,
    .pri_slow_decode, .sys_err, .order_en, .immediate_retry_en,
    .park_on_bridge, .pri_idp_expired, .sec_idp_expired);
  bcr_far_model far (.clk, .nrst, .cmd, .mst, .pri_stop_req, .pri_pending,
    .sec_bus_idle, .downstream_txn, .secondary_clock_request_signal,
    .arb_timer_expired, .sec_retried, .sec_delayed);
  // ********
  // Tasks
  // ********
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for the answer without a local limit; the cycle ceiling ends hangs
  task automatic bus(input logic w, input logic [7:0] i,
      input logic [31:0] d);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    expq.push_back(e);
    bus(0, i, 0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Read data is taken only at the acknowledge edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, expq.pop_front());
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    chk(cfg, 8'hA6);
    rd(8'h5B, 32'h00);
    rd(8'h5C, 32'h1040);
    bus(1, 8'h5B, 32'hFF);
    rd(8'h5B, 32'h1E);
    bus(1, 8'h40, 32'hFFFF);
    rd(8'h40, 32'h0);
    // Only the upper diagnostic byte lane is written here
    avs_byteenable <= 4'h2;
    bus(1, 8'h5C, 32'h0);
    avs_byteenable <= 4'hF;
    rd(8'h5C, 32'h0040);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'hFFFF : rnd();
      bus(1, 8'h5C, r);
      rd(8'h5C, r & 32'hFCFF);
      wt(2);
      chk(cfg, {~r[14], r[13:10], r[6], ~r[2], r[1]});
    end
    for (int i = 0; i < 7; i++) begin
      bus(1, 8'h5B, cv[i]);
      cmd <= {3'b000, fv[i]};
      wt(12);
      chk(sec_clk_stop, ev[i]);
      if (ev[i]) begin
        chk(pri_keep_clk_req, cv[i][2]);
        rd(8'h5B, cv[i] | 8'h01);
      end
      cmd <= {1'b0, i[0], !i[0], fv[i]};
      wt(8);
      chk(sec_clk_stop, 0);
      cmd <= '0;
      wt(2);
    end
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      bus(1, 8'h5C, i ? 32'h1040 : 32'h90C0);
      mst <= r[7:0];
      cmd <= 6'h20;
      wt(6);
      chk(sec_top_tier, i ? 4'h0 : r[7:4] | r[3:0]);
      chk(sys_err, !i);
    end
    cmd <= '0;
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h5C, dv[i]);
      pri_txn_start <= 1;
      sec_txn_start <= 1;
      @(posedge clk);
      pri_txn_start <= 0;
      sec_txn_start <= 0;
      pc = 0;
      sc = 0;
      for (int t = 1; t < 80; t++) begin
        @(posedge clk);
        // Last case reaches the data phase early, so nothing may expire
        pri_data_phase <= (i == 3 && t == 4);
        sec_data_phase <= (i == 3 && t == 4);
        if (pri_idp_expired === 1'b1 && pc == 0) pc = t;
        if (sec_idp_expired === 1'b1 && sc == 0) sc = t;
      end
      chk(pc >= pe[i] && pc <= pe[i] + 2, 1);
      chk(sc >= se[i] && sc <= se[i] + 2, 1);
    end
    print_verdict();
  end
endmodule // tb_top
bind bcr_ctrl bcr_checker #(.NUM_MASTERS(NUM_MASTERS)) u_chk (.clk, .nrst,
  .avs_read, .avs_write, .avs_waitrequest, .downstream_txn,
  .secondary_clock_request_signal, .arb_timer_expired, .sec_retried,
  .sec_delayed, .sec_clk_stop, .pri_keep_clk_req, .sec_top_tier, .sys_err,
  .pri_idp_expired, .sec_idp_expired);
